// file: src/nfl_ctrl.sv
/*
 * Fuse read, lock write and EEPROM page buffer / page command engine,
 * with its AXI4-Lite register slave and processor data-space port.
 * Assumes processor strobes and the external-path level are on clk.
 */
`include "nfl_consts.svh"
`default_nettype none
module nfl_ctrl (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Processor data space and program-memory triggers
   input  wire logic [15:0] dsp_addr,
   input  wire logic        dsp_wr,
   input  wire logic [7:0]  dsp_wdata,
   input  wire logic        dsp_rd,
   output var  logic [7:0]  dsp_rdata,
   input  wire logic        program_memory_load,
   input  wire logic        program_memory_store,
   // Mode and status
   input  wire logic        ext_prog,
   output var  logic        cpu_halt,
   output var  logic        nvm_busy,
   output var  logic        flash_buf_clear
);
   import nfl_pkg::*;

   localparam int          OPC  = `NFL_OP_CYCLES;
   localparam logic [63:0] FUSE = `NFL_FUSE_VALUES;

   typedef struct packed {
      nfl_state_e        st;
      nfl_cmd_t          cmd;
      logic [15:0]       addr;
      logic [7:0]        data_byte_zero;
      nfl_cmd_t          op;
      logic [3:0]        cnt;
      logic [1:0]        halt_cnt;
      logic [4:0]        unlock_cnt;
      logic [7:0]        lock;
      logic [63:0][7:0]  ee_mem;
      logic [7:0][7:0]   pbuf;
      logic [7:0]        ptag;
      logic              flash_clr;
      logic              halt;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic [7:0]        dsp_rdata;
   } nfl_state_s;

   nfl_state_s q;
   nfl_state_s n;

   logic       wr_go;
   logic       rd_go;
   logic       exec_req;
   logic       trig;
   logic       cmd_known;
   logic       cmd_prot;
   logic       unlocked;
   logic       go;
   logic       ee_hit;
   logic       ee_store;
   logic [2:0] pg;

   // Bus handshakes and command start decode
   always_comb begin
      wr_go     = q.awready && s_axi_awvalid && q.wready && s_axi_wvalid;
      rd_go     = q.arready && s_axi_arvalid;
      exec_req  = wr_go && s_axi_awaddr == `NFL_OFS_CONTROL_A
                  && s_axi_wstrb[0] && s_axi_wdata[`NFL_EXEC_BIT]; // R2
      trig      = exec_req
                  || (program_memory_load && q.cmd == `NFL_CMD_RD_FUSE)
                  || (program_memory_store
                      && q.cmd == `NFL_CMD_WR_LOCK); // R10 R8
      cmd_known = q.cmd inside {`NFL_CMD_RD_FUSE, `NFL_CMD_WR_LOCK,
                                `NFL_CMD_BUF_CLR, `NFL_CMD_EE_ERASE,
                                `NFL_CMD_PG_ERASE, `NFL_CMD_PG_WRITE,
                                `NFL_CMD_PG_EWR}; // R1 R15 R16
      cmd_prot  = q.cmd != `NFL_CMD_RD_FUSE; // R3
      unlocked  = q.unlock_cnt != 5'h00;
      // Busy engine drops new triggers so the running command completes
      go        = trig && q.st == NFL_IDLE && cmd_known
                  && (!cmd_prot || unlocked || ext_prog); // R24 R3 R4
      ee_hit    = dsp_addr[15:`NFL_PAGE_MSB+1]
                  == 10'(`NFL_EE_BASE >> (`NFL_PAGE_MSB + 1)); // R11 R13
      ee_store  = dsp_wr && ee_hit;
      pg        = q.addr[`NFL_PAGE_MSB:`NFL_BYTE_MSB+1]; // R12
   end

   // Next-state logic for the whole block
   always_comb begin
      n           = q;
      n.flash_clr = 1'b0;
      if (q.unlock_cnt != 5'h00) begin
         n.unlock_cnt = q.unlock_cnt - 5'h01;
      end
      if (q.halt_cnt != 2'h0) begin
         n.halt_cnt = q.halt_cnt - 2'h1;
      end

      // Write channel: take address and data together
      n.awready = 1'b0;
      n.wready  = 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end
      if (q.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp  = 2'b00;
         case (s_axi_awaddr)
            `NFL_OFS_CMD: begin
               // Parameters frozen while an operation runs
               if (s_axi_wstrb[0] && q.st == NFL_IDLE) begin
                  n.cmd = s_axi_wdata[6:0];
               end
            end
            `NFL_OFS_ADDR: begin
               if (q.st == NFL_IDLE) begin
                  if (s_axi_wstrb[0]) begin
                     n.addr[7:0] = s_axi_wdata[7:0];
                  end
                  if (s_axi_wstrb[1]) begin
                     n.addr[15:8] = s_axi_wdata[15:8];
                  end
               end
            end
            `NFL_OFS_DATA_BYTE_ZERO: begin
               if (s_axi_wstrb[0] && q.st == NFL_IDLE) begin
                  n.data_byte_zero = s_axi_wdata[7:0];
               end
            end
            `NFL_OFS_UNLOCK: begin
               if (s_axi_wstrb[0] && s_axi_wdata[7:0] == `NFL_UNLOCK_KEY)
               begin
                  n.unlock_cnt = 5'(`NFL_UNLOCK_CYC);
               end
            end
            `NFL_OFS_CONTROL_A, `NFL_OFS_STATUS, `NFL_OFS_LOCK: begin
               n.bresp = 2'b00;
            end
            default: begin
               n.bresp = 2'b10;
            end
         endcase
      end

      // Read channel
      n.arready = 1'b0;
      if (s_axi_arvalid && !q.arready && !q.rvalid) begin
         n.arready = 1'b1;
      end
      if (q.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp  = 2'b00;
         n.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            `NFL_OFS_CMD:  n.rdata[6:0]  = q.cmd;
            `NFL_OFS_ADDR: n.rdata[15:0] = q.addr;
            `NFL_OFS_DATA_BYTE_ZERO: begin
               // Reading data byte zero under the EEPROM read command fetches one EEPROM byte
               if (q.cmd == `NFL_CMD_RD_EE && q.st == NFL_IDLE) begin
                  n.data_byte_zero = q.ee_mem[q.addr[`NFL_PAGE_MSB:0]]; // R17
                  n.rdata[7:0] = q.ee_mem[q.addr[`NFL_PAGE_MSB:0]];
               end else begin
                  n.rdata[7:0] = q.data_byte_zero;
               end
            end
            `NFL_OFS_STATUS: begin
               n.rdata[`NFL_ST_BUSY]     = q.st == NFL_RUN;
               n.rdata[`NFL_ST_HALT]     = q.halt;
               n.rdata[`NFL_ST_UNLOCKED] = unlocked;
            end
            `NFL_OFS_LOCK:                          n.rdata[7:0] = q.lock;
            `NFL_OFS_CONTROL_A, `NFL_OFS_UNLOCK:    n.rdata = 32'h0;
            default:                                n.rresp = 2'b10;
         endcase
      end

      // Command engine: fixed duration, effect applied at the end
      case (q.st)
         NFL_IDLE: begin
            if (go) begin
               n.st  = NFL_RUN; // R5 R9 R18
               n.op  = q.cmd;
               n.cnt = 4'(OPC - 1);
            end
         end
         NFL_RUN: begin
            if (q.cnt != 4'h0) begin
               n.cnt = q.cnt - 4'h1;
            end else begin
               n.st = NFL_IDLE;
               case (q.op)
                  `NFL_CMD_RD_FUSE: begin
                     n.data_byte_zero = FUSE[{q.addr[2:0], 3'b000} +: 8]; // R9
                  end
                  `NFL_CMD_WR_LOCK: begin
                     // AND only clears bits: protection never loosens
                     n.lock = q.lock
                              & (q.data_byte_zero | ~`NFL_PROT_MASK); // R6
                     n.ptag      = 8'h00; // R7
                     n.pbuf      = '1;
                     n.flash_clr = 1'b1;
                  end
                  `NFL_CMD_BUF_CLR: begin
                     n.ptag = 8'h00; // R15
                     n.pbuf = '1;
                  end
                  `NFL_CMD_PG_ERASE: begin
                     for (int i = 0; i < 8; i++) begin
                        if (q.ptag[i]) begin
                           n.ee_mem[{pg, 3'(i)}] = 8'hff; // R19
                        end
                     end
                  end
                  `NFL_CMD_PG_WRITE: begin
                     // Programming only pulls bits low
                     for (int i = 0; i < 8; i++) begin
                        if (q.ptag[i]) begin
                           n.ee_mem[{pg, 3'(i)}] =
                              q.ee_mem[{pg, 3'(i)}] & q.pbuf[i]; // R20
                        end
                     end
                  end
                  `NFL_CMD_PG_EWR: begin
                     // Erase and write in one step, cannot be split
                     for (int i = 0; i < 8; i++) begin
                        if (q.ptag[i]) begin
                           n.ee_mem[{pg, 3'(i)}] = q.pbuf[i]; // R22
                        end
                     end
                  end
                  `NFL_CMD_EE_ERASE: begin
                     for (int p = 0; p < 8; p++) begin
                        for (int i = 0; i < 8; i++) begin
                           if (q.ptag[i]) begin
                              n.ee_mem[{3'(p), 3'(i)}] = 8'hff; // R23
                           end
                        end
                     end
                  end
                  default: begin
                     n.st = NFL_IDLE;
                  end
               endcase
            end
         end
         default: begin
            n.st = NFL_IDLE;
         end
      endcase

      // Data space after the engine: a store beats a same-cycle clear
      if (dsp_rd && ee_hit) begin
         n.dsp_rdata = q.ee_mem[dsp_addr[`NFL_PAGE_MSB:0]]; // R11
      end
      if (ee_store) begin
         n.pbuf[dsp_addr[`NFL_BYTE_MSB:0]] = dsp_wdata; // R13
         n.ptag[dsp_addr[`NFL_BYTE_MSB:0]] = 1'b1;
         n.halt_cnt = 2'(`NFL_STORE_HALT); // R14
      end

      // Stall only for fuse/lock commands and buffer loads
      n.halt = n.halt_cnt != 2'h0
               || (n.st == NFL_RUN && (n.op == `NFL_CMD_RD_FUSE
                   || n.op == `NFL_CMD_WR_LOCK)); // R5 R9 R18
   end

   // State register, EEPROM comes up erased
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q        <= '0;
         q.lock   <= `NFL_LOCK_INIT;
         q.ee_mem <= '1;
         q.pbuf   <= '1;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from the state register
   always_comb begin
      s_axi_awready   = q.awready;
      s_axi_wready    = q.wready;
      s_axi_bvalid    = q.bvalid;
      s_axi_bresp     = q.bresp;
      s_axi_arready   = q.arready;
      s_axi_rvalid    = q.rvalid;
      s_axi_rresp     = q.rresp;
      s_axi_rdata     = q.rdata;
      dsp_rdata       = q.dsp_rdata;
      cpu_halt        = q.halt;
      nvm_busy        = q.st == NFL_RUN;
      flash_buf_clear = q.flash_clr;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_busy_run;
      nvm_busy [*8] ##1 !nvm_busy;
   endsequence

   property p_busy_len;
      go |=> s_busy_run;
   endproperty
   a_busy_len: assert property (p_busy_len) // R18
      else $error("busy length wrong");

   property p_nop;
      exec_req && q.cmd == `NFL_CMD_NOP && !nvm_busy |=> !nvm_busy;
   endproperty
   a_nop: assert property (p_nop) // R1
      else $error("no-op started engine");

   property p_locked_out;
      exec_req && cmd_prot && !unlocked && !ext_prog && !nvm_busy
         |=> !nvm_busy;
   endproperty
   a_locked_out: assert property (p_locked_out) // R3
      else $error("protected command ran without unlock");

   property p_ext;
      exec_req && cmd_known && ext_prog && !nvm_busy |=> nvm_busy;
   endproperty
   a_ext: assert property (p_ext) // R4
      else $error("external path refused");

   property p_fuse_halt;
      go && q.cmd == `NFL_CMD_RD_FUSE |=> (cpu_halt && nvm_busy) [*8];
   endproperty
   a_fuse_halt: assert property (p_fuse_halt) // R9
      else $error("fuse read not stalling");

   property p_lock_tight;
      (q.lock & ~$past(q.lock)) == 8'h00;
   endproperty
   a_lock_tight: assert property (p_lock_tight) // R6
      else $error("lock bits relaxed");

   property p_lock_clr;
      nvm_busy && q.op == `NFL_CMD_WR_LOCK && q.cnt == 4'h0
         |=> flash_buf_clear && q.ptag == 8'h00;
   endproperty
   a_lock_clr: assert property (p_lock_clr) // R7
      else $error("buffers not cleared by lock write");

   property p_store_halt;
      ee_store |=> cpu_halt ##1 cpu_halt;
   endproperty
   a_store_halt: assert property (p_store_halt) // R14
      else $error("store stall too short");

   property p_ee_free;
      nvm_busy && q.op[6:4] == 3'h3 && q.halt_cnt == 2'h0 |-> !cpu_halt;
   endproperty
   a_ee_free: assert property (p_ee_free) // R18
      else $error("EEPROM command stalled processor");

   property p_ignore;
      nvm_busy && exec_req |=> $stable(q.op);
   endproperty
   a_ignore: assert property (p_ignore) // R24
      else $error("command replaced while busy");

endmodule // nfl_ctrl
`default_nettype wire

// file: src/nfl_consts.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * nonvolatile fuse, lock and EEPROM command block.
 * Assumes a 250 MHz system clock and AXI4-Lite byte addresses.
 */
// Contract
// R1: Seven-bit command field; 0x00 nothing, 0x07 fuse read, 0x08 lock write.
// R2: Action commands start only on setting execute bit with matching command.
// R3: Lock write and EEPROM commands need unlock window; fuse read does not.
// R4: External programming path accepts execute without unlock.
// R5: Lock write takes data byte zero; busy and stall until done.
// R6: Lock write only tightens protection bits, never relaxes them.
// R7: Lock write clears EEPROM and flash page buffers.
// R8: Lock write accepted from boot loader or application code alike.
// R9: Fuse read uses address register, stalls processor, result in data byte.
// R10: Read-triggered start on program load, write-triggered on program store.
// R11: EEPROM mapped in data space; byte or page writes, byte reads.
// R12: Low address bits pick byte in page, upper bits pick page.
// R13: Stores fill page buffer by low bits; full address must hit EEPROM.
// R14: Each page buffer store stalls processor two cycles.
// R15: 0x36 clears page buffer, 0x30 erases EEPROM; no address needed.
// R16: 0x32 page erase, 0x34 page write, 0x35 erase-write; page from address.
// R17: EEPROM read command starts on software read of data byte zero.
// R18: EEPROM buffer and page commands hold busy without stalling.
// R19: Page erase clears only tagged loaded locations of the page.
// R20: Page write programs only tagged loaded locations.
// R21: Software loads command, then page address, then sets execute.
// R22: Erase-then-write runs as one uninterruptible operation.
// R23: EEPROM erase clears tagged locations in every page.
// R24: Execute bit ignored while busy.
`ifndef NFL_CONSTS_SVH
`define NFL_CONSTS_SVH

// Register byte offsets
`define NFL_OFS_CMD            8'h00
`define NFL_OFS_CONTROL_A      8'h04
`define NFL_OFS_ADDR           8'h08
`define NFL_OFS_DATA_BYTE_ZERO 8'h0c
`define NFL_OFS_STATUS         8'h10
`define NFL_OFS_LOCK           8'h14
`define NFL_OFS_UNLOCK         8'h18

// Field positions
`define NFL_EXEC_BIT      0
`define NFL_ST_BUSY       0
`define NFL_ST_HALT       1
`define NFL_ST_UNLOCKED   2
`define NFL_BYTE_MSB      2
`define NFL_PAGE_MSB      5

// Command codes
`define NFL_CMD_NOP       7'h00
`define NFL_CMD_RD_EE     7'h06
`define NFL_CMD_RD_FUSE   7'h07
`define NFL_CMD_WR_LOCK   7'h08
`define NFL_CMD_EE_ERASE  7'h30
`define NFL_CMD_PG_ERASE  7'h32
`define NFL_CMD_PG_WRITE  7'h34
`define NFL_CMD_PG_EWR    7'h35
`define NFL_CMD_BUF_CLR   7'h36

// Reset values, unlock key, data-space placement
`define NFL_LOCK_INIT     8'hff
`define NFL_PROT_MASK     8'hff
`define NFL_FUSE_VALUES   64'hff_ff_ff_ff_ff_ff_ff_ff
`define NFL_UNLOCK_KEY    8'h9d
`define NFL_EE_BASE       16'h1000

// Timing
`define NFL_CLK_NS        4
`define NFL_OP_TIME_NS    32
`define NFL_OP_CYCLES     (`NFL_OP_TIME_NS / `NFL_CLK_NS)
`define NFL_STORE_HALT    2
`define NFL_UNLOCK_CYC    16

`endif

// file: src/nfl_pkg.sv
/*
 * Types of the nonvolatile fuse, lock and EEPROM command block.
 * Assumes nfl_consts.svh is on the include path.
 */
`default_nettype none
package nfl_pkg;
   // Engine states, Gray along idle -> run
   typedef enum logic [0:0] {
      NFL_IDLE = 1'b0,
      NFL_RUN  = 1'b1
   } nfl_state_e;

   typedef logic [6:0] nfl_cmd_t;
endpackage
`default_nettype wire

// file: sim/nfl_cpu_model.sv
/*
 * Processor model: data-space stores and loads, program-memory triggers.
 * Assumes it shares clk with nfl_ctrl and obeys the cpu_halt stall.
 */
`default_nettype none
module nfl_cpu_model (
   // Clock, reset and stall
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cpu_halt,
   // Data space
   output var  logic [15:0] dsp_addr,
   output var  logic        dsp_wr,
   output var  logic [7:0]  dsp_wdata,
   output var  logic        dsp_rd,
   input  wire logic [7:0]  dsp_rdata,
   // Program-memory triggers
   output var  logic        program_memory_load,
   output var  logic        program_memory_store
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet core at time zero
   initial begin
      dsp_addr = 16'h0000;
      dsp_wr = 1'b0;
      dsp_wdata = 8'h00;
      dsp_rd = 1'b0;
      program_memory_load = 1'b0;
      program_memory_store = 1'b0;
   end

   // A stalled core issues nothing until the stall ends
   task automatic slot();
      @(posedge clk);
      while (cpu_halt || !rst_n) @(posedge clk);
   endtask

   // Store; released lines show the inverse, not the old value
   task automatic store(input logic [15:0] a, input logic [7:0] d);
      slot();
      dsp_addr  <= a;
      dsp_wdata <= d;
      dsp_wr    <= 1'b1;
      @(posedge clk);
      dsp_wr    <= 1'b0;
      dsp_addr  <= ~a;
      dsp_wdata <= ~d;
   endtask

   // Load; data is registered, so taken one edge later
   task automatic load(input logic [15:0] a, output logic [7:0] d);
      slot();
      dsp_addr <= a;
      dsp_rd   <= 1'b1;
      @(posedge clk);
      dsp_rd   <= 1'b0;
      dsp_addr <= ~a;
      @(posedge clk);
      d = dsp_rdata;
   endtask

   // One-cycle program-memory load or store instruction
   task automatic trig(input bit st);
      slot();
      if (st)
         program_memory_store <= 1'b1;
      else
         program_memory_load <= 1'b1;
      @(posedge clk);
      program_memory_store <= 1'b0;
      program_memory_load  <= 1'b0;
   endtask
endmodule // nfl_cpu_model
`default_nettype wire

// file: sim/nvm_fuse_lock_eeprom_cmds_bench.sv
/*
 * Self-checking bench of the fuse, lock and EEPROM command block.
 * Assumes nfl_ctrl, nfl_cpu_model and nfl_consts.svh are available.
 */
`include "nfl_consts.svh"
`default_nettype none
module nvm_fuse_lock_eeprom_cmds_bench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  r;
   } nfl_row_s;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        bready = 1'b1, rready = 1'b1, ext_prog = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        halt, busy, fbc, dsp_wr, dsp_rd, pml, pms;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, rv;
   logic [15:0] dsp_addr;
   logic [7:0]  dsp_wdata, dsp_rdata, cv;
   int          errors = 0, cmp_count = 0;
   int          bc = 0, hc = 0, fc = 0, b0, h0, f0;

   // Plain register accesses after reset
   nfl_row_s rows [9] = '{
      '{1'b0, 8'h14, 32'hff, 2'b00},
      '{1'b0, 8'h10, 32'h00, 2'b00},
      '{1'b0, 8'h04, 32'h00, 2'b00},
      '{1'b0, 8'h1c, 32'h00, 2'b10},
      '{1'b1, 8'h1c, 32'h00, 2'b10},
      '{1'b1, 8'h08, 32'h0123, 2'b00},
      '{1'b0, 8'h08, 32'h0123, 2'b00},
      '{1'b1, 8'h00, 32'h07, 2'b00},
      '{1'b0, 8'h00, 32'h07, 2'b00}
   };

   nfl_ctrl DUT (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready),
      .dsp_addr(dsp_addr), .dsp_wr(dsp_wr), .dsp_wdata(dsp_wdata),
      .dsp_rd(dsp_rd), .dsp_rdata(dsp_rdata),
      .program_memory_load(pml), .program_memory_store(pms),
      .ext_prog(ext_prog), .cpu_halt(halt), .nvm_busy(busy),
      .flash_buf_clear(fbc)
   );

   nfl_cpu_model cpu (
      .clk(clk), .rst_n(rst_n), .cpu_halt(halt),
      .dsp_addr(dsp_addr), .dsp_wr(dsp_wr), .dsp_wdata(dsp_wdata),
      .dsp_rd(dsp_rd), .dsp_rdata(dsp_rdata),
      .program_memory_load(pml), .program_memory_store(pms)
   );

   always #2 clk = ~clk;

   // Running totals of busy, stall and flash-clear cycles
   always @(posedge clk) begin
      bc <= bc + int'(busy === 1'b1);
      hc <= hc + int'(halt === 1'b1);
      fc <= fc + int'(fbc === 1'b1);
   end

   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
   endtask

   // Only the watchdog ends a wait for the answer
   task automatic rd(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rv = rdata;
      rs = rresp;
   endtask

   // Command, then address, optional unlock, then execute and settle
   task automatic cmd(input logic [6:0] c, input logic [15:0] a,
                      input bit u);
      wr(8'h00, {25'h0, c});
      wr(8'h08, {16'h0, a});
      if (u) wr(8'h18, 32'h9d);
      b0 = bc;
      h0 = hc;
      wr(8'h04, 32'h1);
      repeat (12) @(posedge clk);
   endtask

   // EEPROM byte through the data-byte read trigger
   task automatic ee(input logic [15:0] a, input logic [7:0] e);
      wr(8'h00, 32'h06);
      wr(8'h08, {16'h0, a});
      rd(8'h0c);
      chk("eeprom", {24'h0, e}, rv);
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Cut a hang short; the run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("busy", 0, {31'h0, busy});
      chk("halt", 0, {31'h0, halt});
      foreach (rows[i]) begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         else begin
            rd(rows[i].a);
            chk("rdata", rows[i].d, rv);
         end
         chk("resp", {30'h0, rows[i].r}, {30'h0, rs});
      end
      // Protected command without unlock must not start
      cmd(7'h36, 16'h0000, 1'b0);
      chk("busy", 0, bc - b0);
      // No-op with the unlock window open still leaves the engine idle
      cmd(7'h00, 16'h0000, 1'b1);
      chk("busy", 0, bc - b0);
      // Fuse read needs no unlock and stalls the core
      wr(8'h0c, 32'h0);
      cmd(7'h07, 16'h0003, 1'b0);
      chk("busy", `NFL_OP_CYCLES, bc - b0);
      chk("halt", `NFL_OP_CYCLES, hc - h0);
      rd(8'h0c);
      chk("fuse", 32'hff, rv);
      // Buffer stores: only a real EEPROM address loads and stalls
      h0 = hc;
      cpu.store(16'h1013, 8'ha5);
      repeat (4) @(posedge clk);
      chk("st_halt", `NFL_STORE_HALT, hc - h0);
      h0 = hc;
      cpu.store(16'h2013, 8'h5a);
      repeat (4) @(posedge clk);
      chk("st_halt", 0, hc - h0);
      cmd(7'h34, 16'h0010, 1'b1);
      chk("busy", `NFL_OP_CYCLES, bc - b0);
      chk("halt", 0, hc - h0);
      cpu.load(16'h1013, cv);
      chk("load", 32'ha5, {24'h0, cv});
      ee(16'h0013, 8'ha5);
      ee(16'h0012, 8'hff);
      // Page erase with a second command and execute while busy
      wr(8'h00, 32'h32);
      wr(8'h08, 32'h10);
      wr(8'h18, 32'h9d);
      b0 = bc;
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h30);
      wr(8'h04, 32'h1);
      repeat (12) @(posedge clk);
      chk("busy", `NFL_OP_CYCLES, bc - b0);
      rd(8'h00);
      chk("cmd", 32'h32, rv);
      ee(16'h0013, 8'hff);
      // Erase-then-write into two pages, then erase across pages
      cmd(7'h35, 16'h0028, 1'b1);
      ee(16'h002b, 8'ha5);
      ee(16'h002a, 8'hff);
      cmd(7'h35, 16'h0010, 1'b1);
      cmd(7'h30, 16'h0000, 1'b1);
      ee(16'h002b, 8'hff);
      ee(16'h0013, 8'hff);
      // Cleared buffer leaves a page write with nothing to program
      cmd(7'h36, 16'h0000, 1'b1);
      cmd(7'h34, 16'h0028, 1'b1);
      ee(16'h002b, 8'hff);
      // Lock write over the external path, no unlock
      cpu.store(16'h1011, 8'h3c);
      ext_prog <= 1'b1;
      wr(8'h0c, 32'hf0);
      f0 = fc;
      cmd(7'h08, 16'h0000, 1'b0);
      chk("halt", `NFL_OP_CYCLES, hc - h0);
      chk("fbc", 1, fc - f0);
      rd(8'h14);
      chk("lock", 32'hf0, rv);
      ext_prog <= 1'b0;
      cmd(7'h34, 16'h0010, 1'b1);
      ee(16'h0011, 8'hff);
      // Store-triggered lock write trying to relax protection
      wr(8'h0c, 32'hff);
      wr(8'h00, 32'h08);
      wr(8'h18, 32'h9d);
      h0 = hc;
      cpu.trig(1'b1);
      repeat (12) @(posedge clk);
      chk("halt", `NFL_OP_CYCLES, hc - h0);
      rd(8'h14);
      chk("lock", 32'hf0, rv);
      // Load-triggered fuse read
      wr(8'h0c, 32'h0);
      wr(8'h00, 32'h07);
      cpu.trig(1'b0);
      repeat (12) @(posedge clk);
      rd(8'h0c);
      chk("fuse", 32'hff, rv);
      // Mid-run reset, held long enough to cover the lock history check
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("busy", 0, {31'h0, busy});
      rd(8'h14);
      chk("lock", {24'h0, `NFL_LOCK_INIT}, rv);
      report_and_stop();
   end
endmodule // nvm_fuse_lock_eeprom_cmds_bench
`default_nettype wire
